// >>> rtl/rtc_pkg.sv
// Constants, register map and field layouts for the interrupt routing,
// trimming and oscillator-halt block.
// Assumes a 25 MHz system clock and a 32.768/32.000 kHz crystal clock.
package rtc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_TRIM     = 4'h7;
  localparam logic [3:0] OFS_ALA_MIN  = 4'h8;
  localparam logic [3:0] OFS_ALA_HR   = 4'h9;
  localparam logic [3:0] OFS_ALA_WDAY = 4'hA;
  localparam logic [3:0] OFS_ALB_MIN  = 4'hB;
  localparam logic [3:0] OFS_ALB_HR   = 4'hC;
  localparam logic [3:0] OFS_ALB_WDAY = 4'hD;
  localparam logic [3:0] OFS_CTRL1    = 4'hE;
  localparam logic [3:0] OFS_CTRL2    = 4'hF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h10;
  localparam logic [6:0] TRIM_RST  = 7'h00;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic       alarm_a_enable;
    logic       alarm_b_enable;
    logic [1:0] output_route_select;
    logic       test;
    logic [2:0] periodic_select;
  } rtc_ctrl1_t;

  typedef struct packed {
    logic [1:0] zero;
    logic       crystal_freq_select;
    logic       osc_halt_flag;
    logic       clkout_disable_n;
    logic       periodic_flag;
    logic       alarm_a_flag;
    logic       alarm_b_flag;
  } rtc_ctrl2_t;

  // Periodic select codes
  localparam logic [2:0] PER_OFF   = 3'h0;
  localparam logic [2:0] PER_LOW   = 3'h1;
  localparam logic [2:0] PER_2HZ   = 3'h2;
  localparam logic [2:0] PER_1HZ   = 3'h3;
  localparam logic [2:0] PER_SEC   = 3'h4;
  localparam logic [2:0] PER_MIN   = 3'h5;
  localparam logic [2:0] PER_HOUR  = 3'h6;
  localparam logic [2:0] PER_MONTH = 3'h7;

  // ==========================================================
  // Timekeeping and trimming
  localparam logic [16:0] PULSES_32K768 = 17'h08000;
  localparam logic [16:0] PULSES_32K000 = 17'h07D00;
  localparam logic [4:0]  TRIM_WIN_SEC  = 5'h14;
  localparam logic [6:0]  TRIM_POS_MIN  = 7'h02;
  localparam logic [6:0]  TRIM_POS_MAX  = 7'h3F;
  localparam logic [6:0]  TRIM_NEG_MIN  = 7'h42;
  localparam logic [7:0]  TRIM_NEG_BASE = 8'h80;

  // ==========================================================
  // Halt detection timing
  localparam int         SYS_CLK_KHZ  = 25000;
  localparam int         HALT_TIME_NS = 100000;
  localparam int         HALT_CYC_INT = HALT_TIME_NS / 1000
                                        * SYS_CLK_KHZ / 1000;
  localparam logic [11:0] HALT_CYC    = 12'(HALT_CYC_INT);

endpackage : rtc_pkg

// >>> rtl/rtc_osc_timebase.sv
// Crystal-clock timebase: trimmed second counter and pulse-mode waves.
// Assumes configuration words are held stable around cfg_toggle_in flips.
`timescale 1ns/1ps
module rtc_osc_timebase (
  // Crystal clock
  input  wire logic       osc_clk_in,
  // System-domain controls
  input  wire logic       rst_in,
  input  wire logic [6:0] trim_code_in,
  input  wire logic       xtal_sel_in,
  input  wire logic       cfg_toggle_in,
  // Crystal-domain levels
  output logic            sec_toggle_out,
  output logic            wave_1hz_low_out,
  output logic            wave_2hz_low_out
);
  import rtc_pkg::*;

  logic [1:0]  rst_sync_ff;
  logic [2:0]  tog_sync_ff;
  logic [6:0]  trim_ff,  nxt_trim;
  logic        xsel_ff,  nxt_xsel;
  logic [16:0] cnt_ff,   nxt_cnt;
  logic [4:0]  sec20_ff, nxt_sec20;
  logic        tog_ff,   nxt_tog;
  logic        w1_ff,    nxt_w1;
  logic        w2_ff,    nxt_w2;
  logic [16:0] base, len, half, quarter;
  logic        last;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_trim = trim_ff;
    nxt_xsel = xsel_ff;
    if (tog_sync_ff[2] ^ tog_sync_ff[1]) begin
      nxt_trim = trim_code_in;
      nxt_xsel = xtal_sel_in;
    end
    base    = xsel_ff ? PULSES_32K000 : PULSES_32K768;
    half    = base >> 1;
    quarter = base >> 2;
    len     = base;
    // One second in every window gets a different pulse count
    if (sec20_ff == 5'h00) begin // R23
      if (trim_ff >= TRIM_POS_MIN && trim_ff <= TRIM_POS_MAX) begin
        len = base + {9'h000, trim_ff - 7'h01, 1'b0}; // R02 R03 R05
      end else if (trim_ff >= TRIM_NEG_MIN) begin
        len = base - {9'h000, 7'(TRIM_NEG_BASE - {1'b0, trim_ff}),
                      1'b0}; // R01 R04 R05
      end // R24
    end
    last      = (cnt_ff == len - 17'h00001);
    nxt_cnt   = last ? 17'h00000 : cnt_ff + 17'h00001;
    nxt_sec20 = sec20_ff;
    if (last) begin
      nxt_sec20 = (sec20_ff == TRIM_WIN_SEC - 5'h01) ? 5'h00
                                                     : sec20_ff + 5'h01;
    end
    nxt_tog = tog_ff ^ last;
    nxt_w1  = nxt_cnt < half;
    nxt_w2  = (nxt_cnt < quarter) ||
              (nxt_cnt >= half && nxt_cnt < half + quarter);
  end

  always_ff @(posedge osc_clk_in) begin
    rst_sync_ff <= {rst_sync_ff[0], rst_in};
    tog_sync_ff <= {tog_sync_ff[1:0], cfg_toggle_in};
    if (rst_sync_ff[1]) begin
      trim_ff  <= TRIM_RST;
      xsel_ff  <= 1'b0;
      cnt_ff   <= 17'h00000;
      sec20_ff <= 5'h00;
      tog_ff   <= 1'b0;
      w1_ff    <= 1'b1;
      w2_ff    <= 1'b1;
    end else begin
      trim_ff  <= nxt_trim;
      xsel_ff  <= nxt_xsel;
      cnt_ff   <= nxt_cnt;
      sec20_ff <= nxt_sec20;
      tog_ff   <= nxt_tog;
      w1_ff    <= nxt_w1;
      w2_ff    <= nxt_w2;
    end
  end

  assign sec_toggle_out   = tog_ff;
  assign wave_1hz_low_out = w1_ff;
  assign wave_2hz_low_out = w2_ff;

endmodule : rtc_osc_timebase

// >>> rtl/rtc_irq_core.sv
// Interrupt routing, time trimming control and oscillator-halt flag.
// Assumes a calendar counter in the system domain and a free crystal clock.
// Behaviour
// R01: Trim codes for slow clock are two's complement, magnitude 80h minus code.
// R02: Trim codes for fast clock count upward from 01h.
// R03: At 32.768 kHz, codes 02h..3Fh slow time 3.05 to 189.2 ppm.
// R04: At 32.768 kHz, codes 7Fh..42h speed time 3.05 to 189.2 ppm.
// R05: At 32.000 kHz, one step is 3.125 ppm, range about 193.7 ppm.
// R06: Trimming never alters the raw crystal clock on pin B.
// R07: Host computes trim value from frequency error, about error times ten.
// R08: Host avoids unrelated accesses above twice a second while trimming.
// R09: Host writes halt flag 0 to arm; device sets it on halt.
// R10: While halt flag is 1, control and trim bits are held at 0.
// R11: Halt flag is 1 after power-on.
// R12: Halt flag stays 1 after oscillation resumes until host writes 0.
// R13: Alarm match on weekday, hour, minute pulls its routed pin low.
// R14: Route select steers alarm B and periodic; clock always on pin B (code drives it only while Fh D3 is 0).
// R15: Flags in Fh at D1, D0, D2; enables in Eh at D7, D6.
// R16: With halt flag set after power-up, pin A is released.
// R17: At power-on default the crystal clock is driven on pin B.
// R18: Sources sharing a pin are ORed as active-low requests.
// R19: Host reads the flag register to find which source is active.
// R20: The 32 kHz output is the oscillator clock undivided, untrimmed.
// R21: Periodic source gives pulse mode or level mode held till cleared.
// R22: Alarm units A and B are identical with own enable and flag.
// R23: Trim changes pulse count of one second in every twenty.
// R24: Trim codes 0, +1, -64, -63 apply no correction.
// R25: Periodic codes: off, low, 2 Hz, 1 Hz, second, minute, hour, month.
// R26: Host programs alarm time while enable is 0, then enables.
// R27: Interrupt pins are open-drain: only a pull-low enable is driven.
`timescale 1ns/1ps
module rtc_irq_core (
  // System clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Crystal clock
  input  wire logic       osc_clk_in,
  // Register access
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  // Calendar counter
  input  wire logic [2:0] cal_weekday_in,
  input  wire logic [7:0] cal_hour_in,
  input  wire logic [7:0] cal_minute_in,
  input  wire logic       cal_min_roll_in,
  input  wire logic       cal_hour_roll_in,
  input  wire logic       cal_month_roll_in,
  output logic            sec_tick_out,
  // Open-drain interrupt pins
  output logic            irq_pin_a_o_out,
  output logic            irq_pin_a_oe_out,
  output logic            irq_pin_b_o_out,
  output logic            irq_pin_b_oe_out
);
  import rtc_pkg::*;

  rtc_ctrl1_t ctrl1_ff,   nxt_ctrl1;
  rtc_ctrl2_t ctrl2_ff,   nxt_ctrl2;
  logic [6:0] trim_ff,    nxt_trim;
  logic [7:0] al_min_ff   [2];
  logic [7:0] al_hr_ff    [2];
  logic [6:0] al_wday_ff  [2];
  logic [7:0] nxt_al_min  [2];
  logic [7:0] nxt_al_hr   [2];
  logic [6:0] nxt_al_wday [2];
  logic [1:0] match_prev_ff;
  logic [1:0] match;
  logic       cfg_tog_ff, nxt_cfg_tog;
  logic [7:0] rdata_ff,   nxt_rdata;
  logic [11:0] halt_cnt_ff, nxt_halt_cnt;
  logic       halt_evt;
  logic [2:0] osc_sync_ff;
  logic [2:0] sec_sync_ff;
  logic [1:0] w1_sync_ff;
  logic [1:0] w2_sync_ff;
  logic       sec_evt;
  logic       sec_tick_ff, nxt_sec_tick;
  logic       pin_a_ff,   nxt_pin_a;
  logic       pin_b_ff,   nxt_pin_b;
  logic       clk_en_ff,  nxt_clk_en;
  logic       sec_tog, w1_low, w2_low;
  logic       act_a, act_b, act_p;

  // ==========================================================
  // Crystal-domain timebase
  rtc_osc_timebase u_timebase (
    .osc_clk_in       (osc_clk_in),
    .rst_in           (rst_in),
    .trim_code_in     (trim_ff),
    .xtal_sel_in      (ctrl2_ff.crystal_freq_select),
    .cfg_toggle_in    (cfg_tog_ff),
    .sec_toggle_out   (sec_tog),
    .wave_1hz_low_out (w1_low),
    .wave_2hz_low_out (w2_low)
  );

  // ==========================================================
  // Crossings into the system domain
  always_ff @(posedge clock_in) begin
    osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_in};
    sec_sync_ff <= {sec_sync_ff[1:0], sec_tog};
    w1_sync_ff  <= {w1_sync_ff[0], w1_low};
    w2_sync_ff  <= {w2_sync_ff[0], w2_low};
  end

  assign sec_evt = sec_sync_ff[2] ^ sec_sync_ff[1];

  // ==========================================================
  // Oscillator halt detection
  always_comb begin
    nxt_halt_cnt = halt_cnt_ff;
    halt_evt     = 1'b0;
    if (osc_sync_ff[2] ^ osc_sync_ff[1]) begin
      nxt_halt_cnt = 12'h000;
    end else if (halt_cnt_ff == HALT_CYC - 12'h001) begin
      halt_evt = 1'b1;
    end else begin
      nxt_halt_cnt = halt_cnt_ff + 12'h001;
    end
  end

  // ==========================================================
  // Alarm comparison, one per unit
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_alarm
      assign match[gi] = al_wday_ff[gi][cal_weekday_in] &&
                         al_hr_ff[gi] == cal_hour_in &&
                         al_min_ff[gi] == cal_minute_in; // R13 R22
    end
  endgenerate

  // ==========================================================
  // Registers, flags and reads
  always_comb begin
    nxt_ctrl1   = ctrl1_ff;
    nxt_ctrl2   = ctrl2_ff;
    nxt_trim    = trim_ff;
    nxt_al_min  = al_min_ff;
    nxt_al_hr   = al_hr_ff;
    nxt_al_wday = al_wday_ff;
    nxt_cfg_tog = cfg_tog_ff;
    nxt_rdata   = rdata_ff;

    // Software writes; flags clear on a written 0 only
    if (reg_wr_in) begin
      if (reg_addr_in == OFS_CTRL1) begin
        nxt_ctrl1 = rtc_ctrl1_t'(reg_wdata_in);
      end else if (reg_addr_in == OFS_CTRL2) begin
        nxt_ctrl2.crystal_freq_select = reg_wdata_in[5];
        nxt_ctrl2.clkout_disable_n    = reg_wdata_in[3];
        nxt_ctrl2.osc_halt_flag = ctrl2_ff.osc_halt_flag &
                                  reg_wdata_in[4]; // R09 R12
        nxt_ctrl2.periodic_flag = ctrl2_ff.periodic_flag & reg_wdata_in[2];
        nxt_ctrl2.alarm_a_flag  = ctrl2_ff.alarm_a_flag & reg_wdata_in[1];
        nxt_ctrl2.alarm_b_flag  = ctrl2_ff.alarm_b_flag & reg_wdata_in[0];
        nxt_cfg_tog = ~cfg_tog_ff;
      end else if (reg_addr_in == OFS_TRIM) begin
        nxt_trim    = reg_wdata_in[6:0];
        nxt_cfg_tog = ~cfg_tog_ff;
      end else if (reg_addr_in == OFS_ALA_MIN) begin
        nxt_al_min[0] = reg_wdata_in;
      end else if (reg_addr_in == OFS_ALA_HR) begin
        nxt_al_hr[0] = reg_wdata_in;
      end else if (reg_addr_in == OFS_ALA_WDAY) begin
        nxt_al_wday[0] = reg_wdata_in[6:0];
      end else if (reg_addr_in == OFS_ALB_MIN) begin
        nxt_al_min[1] = reg_wdata_in;
      end else if (reg_addr_in == OFS_ALB_HR) begin
        nxt_al_hr[1] = reg_wdata_in;
      end else if (reg_addr_in == OFS_ALB_WDAY) begin
        nxt_al_wday[1] = reg_wdata_in[6:0];
      end
    end

    // Hardware sets come after the clear so they win
    if (halt_evt) begin
      nxt_ctrl2.osc_halt_flag = 1'b1; // R09
    end
    if (match[0] && !match_prev_ff[0]) begin
      nxt_ctrl2.alarm_a_flag = 1'b1; // R13 R15
    end
    if (match[1] && !match_prev_ff[1]) begin
      nxt_ctrl2.alarm_b_flag = 1'b1; // R13 R15
    end
    if (!nxt_ctrl1.alarm_a_enable) begin
      nxt_ctrl2.alarm_a_flag = 1'b0; // R22
    end
    if (!nxt_ctrl1.alarm_b_enable) begin
      nxt_ctrl2.alarm_b_flag = 1'b0; // R22
    end

    // Periodic flag mirrors the periodic output state
    case (nxt_ctrl1.periodic_select) // R21 R25
      PER_OFF:   nxt_ctrl2.periodic_flag = 1'b0;
      PER_LOW:   nxt_ctrl2.periodic_flag = 1'b1;
      PER_2HZ:   nxt_ctrl2.periodic_flag = w2_sync_ff[1];
      PER_1HZ:   nxt_ctrl2.periodic_flag = w1_sync_ff[1];
      PER_SEC: begin
        if (sec_evt) nxt_ctrl2.periodic_flag = 1'b1;
      end
      PER_MIN: begin
        if (cal_min_roll_in) nxt_ctrl2.periodic_flag = 1'b1;
      end
      PER_HOUR: begin
        if (cal_hour_roll_in) nxt_ctrl2.periodic_flag = 1'b1;
      end
      default: begin
        if (cal_month_roll_in) nxt_ctrl2.periodic_flag = 1'b1;
      end
    endcase

    // Halt flag forces configuration to zero
    if (nxt_ctrl2.osc_halt_flag) begin // R10
      nxt_ctrl1 = rtc_ctrl1_t'(CTRL1_RST);
      nxt_trim  = TRIM_RST;
      if (trim_ff != TRIM_RST || ctrl2_ff.crystal_freq_select) begin
        nxt_cfg_tog = ~cfg_tog_ff;
      end
      nxt_ctrl2.crystal_freq_select = 1'b0;
      nxt_ctrl2.clkout_disable_n    = 1'b0;
      nxt_ctrl2.periodic_flag       = 1'b0;
      nxt_ctrl2.alarm_a_flag        = 1'b0;
      nxt_ctrl2.alarm_b_flag        = 1'b0;
    end
    nxt_ctrl2.zero = 2'h0;

    // Read data
    if (reg_rd_in) begin
      if (reg_addr_in == OFS_CTRL1) begin
        nxt_rdata = ctrl1_ff;
      end else if (reg_addr_in == OFS_CTRL2) begin
        nxt_rdata = ctrl2_ff; // R15 R19
      end else if (reg_addr_in == OFS_TRIM) begin
        nxt_rdata = {1'b0, trim_ff};
      end else if (reg_addr_in == OFS_ALA_MIN) begin
        nxt_rdata = al_min_ff[0];
      end else if (reg_addr_in == OFS_ALA_HR) begin
        nxt_rdata = al_hr_ff[0];
      end else if (reg_addr_in == OFS_ALA_WDAY) begin
        nxt_rdata = {1'b0, al_wday_ff[0]};
      end else if (reg_addr_in == OFS_ALB_MIN) begin
        nxt_rdata = al_min_ff[1];
      end else if (reg_addr_in == OFS_ALB_HR) begin
        nxt_rdata = al_hr_ff[1];
      end else if (reg_addr_in == OFS_ALB_WDAY) begin
        nxt_rdata = {1'b0, al_wday_ff[1]};
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // ==========================================================
  // Pin routing
  always_comb begin
    act_a = ctrl1_ff.alarm_a_enable & ctrl2_ff.alarm_a_flag;
    act_b = ctrl1_ff.alarm_b_enable & ctrl2_ff.alarm_b_flag;
    act_p = ctrl2_ff.periodic_flag;
    nxt_pin_a = act_a | (act_b & ~ctrl1_ff.output_route_select[0]) |
                (act_p & ~ctrl1_ff.output_route_select[1]); // R14 R18 R16
    nxt_pin_b = (act_b & ctrl1_ff.output_route_select[0]) |
                (act_p & ctrl1_ff.output_route_select[1]); // R14 R18
    nxt_clk_en   = ~ctrl2_ff.clkout_disable_n; // R17
    nxt_sec_tick = sec_evt;
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl1_ff      <= rtc_ctrl1_t'(CTRL1_RST);
      ctrl2_ff      <= rtc_ctrl2_t'(CTRL2_RST); // R11
      trim_ff       <= TRIM_RST;
      al_min_ff     <= '{8'h00, 8'h00};
      al_hr_ff      <= '{8'h00, 8'h00};
      al_wday_ff    <= '{7'h00, 7'h00};
      match_prev_ff <= 2'h0;
      cfg_tog_ff    <= 1'b0;
      rdata_ff      <= 8'h00;
      halt_cnt_ff   <= 12'h000;
      sec_tick_ff   <= 1'b0;
      pin_a_ff      <= 1'b0;
      pin_b_ff      <= 1'b0;
      clk_en_ff     <= 1'b1;
    end else begin
      ctrl1_ff      <= nxt_ctrl1;
      ctrl2_ff      <= nxt_ctrl2;
      trim_ff       <= nxt_trim;
      al_min_ff     <= nxt_al_min;
      al_hr_ff      <= nxt_al_hr;
      al_wday_ff    <= nxt_al_wday;
      match_prev_ff <= match;
      cfg_tog_ff    <= nxt_cfg_tog;
      rdata_ff      <= nxt_rdata;
      halt_cnt_ff   <= nxt_halt_cnt;
      sec_tick_ff   <= nxt_sec_tick;
      pin_a_ff      <= nxt_pin_a;
      pin_b_ff      <= nxt_pin_b;
      clk_en_ff     <= nxt_clk_en;
    end
  end

  // Raw crystal clock pulls pin B low in its low phase, untrimmed
  assign irq_pin_b_oe_out = pin_b_ff | (clk_en_ff & ~osc_clk_in); // R06 R20
  assign irq_pin_a_oe_out = pin_a_ff; // R27
  assign irq_pin_a_o_out  = 1'b0; // R27
  assign irq_pin_b_o_out  = 1'b0; // R27
  assign reg_rdata_out    = rdata_ff;
  assign sec_tick_out     = sec_tick_ff;

endmodule : rtc_irq_core

// >>> verif/rtc_irq_asserts.sv
// Port-level checks for the trim, halt and interrupt routing core.
// Bound to rtc_irq_core; sees its ports only.
`timescale 1ns/1ps
module rtc_irq_asserts (
  // Clock, reset and crystal
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       osc_clk_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Outputs
  input wire logic       sec_tick_out,
  input wire logic       irq_pin_a_o_out,
  input wire logic       irq_pin_a_oe_out,
  input wire logic       irq_pin_b_o_out,
  input wire logic       irq_pin_b_oe_out
);
  import rtc_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ========
  // Halt flag surely set: from reset until the host writes it 0
  logic halt_ff;
  logic nxt_halt;
  logic rd_ctl;
  always_comb begin
    nxt_halt = halt_ff;
    if (rst_in)
      nxt_halt = 1'b1;
    else if (reg_wr_in && reg_addr_in == OFS_CTRL2 && !reg_wdata_in[4])
      nxt_halt = 1'b0;
  end
  always_ff @(posedge clock_in) begin
    halt_ff <= nxt_halt;
  end
  assign rd_ctl = reg_rd_in &&
                  (reg_addr_in == OFS_CTRL1 || reg_addr_in == OFS_TRIM);
  // ========
  // Properties
  property p_od; !irq_pin_a_o_out && !irq_pin_b_o_out; endproperty
  a_od: assert property (p_od)
    else $error("interrupt pin driven high");
  property p_halt_f;
    halt_ff && reg_rd_in && !reg_wr_in && reg_addr_in == OFS_CTRL2
    |=> reg_rdata_out == CTRL2_RST;
  endproperty
  a_halt_f: assert property (p_halt_f)
    else $error("flag register wrong while halted");
  property p_halt_ctl; halt_ff && rd_ctl |=> reg_rdata_out == 8'h00;
  endproperty
  a_halt_ctl: assert property (p_halt_ctl)
    else $error("control bits not held clear while halted");
  property p_halt_pa; halt_ff |-> !irq_pin_a_oe_out; endproperty
  a_halt_pa: assert property (p_halt_pa)
    else $error("pin A pulled low while halted");
  property p_halt_pb; halt_ff |-> irq_pin_b_oe_out == !osc_clk_in;
  endproperty
  a_halt_pb: assert property (p_halt_pb)
    else $error("pin B not carrying crystal clock");
  property p_unmap;
    reg_rd_in && reg_addr_in < OFS_TRIM |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_rd_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_tick; sec_tick_out |=> !sec_tick_out [*8]; endproperty
  a_tick: assert property (p_tick)
    else $error("second ticks too close");
  c_pin_a: cover property ($rose(irq_pin_a_oe_out));
  c_pin_b: cover property (!halt_ff && $rose(irq_pin_b_oe_out));
  c_tick: cover property (sec_tick_out);
endmodule : rtc_irq_asserts

bind rtc_irq_core rtc_irq_asserts i_chk (
  .clock_in, .rst_in, .osc_clk_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sec_tick_out,
  .irq_pin_a_o_out, .irq_pin_a_oe_out, .irq_pin_b_o_out, .irq_pin_b_oe_out
);

// >>> verif/rtc_host_model.sv
// Host model: register strobes and pulled-up interrupt lines.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
module rtc_host_model (
  // Clock
  input  wire logic       clock_in,
  // Register port
  input  wire logic [7:0] reg_rdata_in,
  output logic      [3:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  // Open-drain pins
  input  wire logic       pin_a_o_in,
  input  wire logic       pin_a_oe_in,
  input  wire logic       pin_b_o_in,
  input  wire logic       pin_b_oe_in,
  output logic            pin_a_out,
  output logic            pin_b_out
);
  // ========
  // Lines with pull-ups
  assign pin_a_out = pin_a_oe_in ? pin_a_o_in : 1'b1;
  assign pin_b_out = pin_b_oe_in ? pin_b_o_in : 1'b1;
  initial begin
    reg_addr_out  = 4'h0;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end
  // ========
  // Accesses: few, and alarm times set before enables
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
  endtask : wr_reg
  // Flag register tells which source holds a pin
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
    #5;
    d = reg_rdata_in;
  endtask : rd_reg
  // Two's-complement trim code from a signed step count
  function automatic logic [6:0] trim_of(input int steps);
    return 7'(steps);
  endfunction : trim_of
endmodule : rtc_host_model

// >>> verif/rtc_trim_halt_irq_routing_bench.sv
// Self-checking bench for trim, oscillator halt and interrupt routing.
// Host model makes register accesses; the bench drives the calendar.
`timescale 1ns/1ps
module rtc_trim_halt_irq_routing_bench;
  import rtc_pkg::*;
  // ========
  // Clocks, stimulus and counters
  logic       clock_in          = 1'b0;
  logic       osc_clk_in        = 1'b0;
  logic       osc_run           = 1'b1;
  logic       rst_in            = 1'b1;
  logic [2:0] cal_weekday_in    = 3'h0;
  logic [7:0] cal_hour_in       = 8'h00;
  logic [7:0] cal_minute_in     = 8'h00;
  logic       cal_min_roll_in   = 1'b0;
  logic       cal_hour_roll_in  = 1'b0;
  logic       cal_month_roll_in = 1'b0;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_wr_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic       sec_tick_out;
  logic       irq_pin_a_o_out;
  logic       irq_pin_a_oe_out;
  logic       irq_pin_b_o_out;
  logic       irq_pin_b_oe_out;
  logic       pin_a;
  logic       pin_b;
  int         fail_count        = 0;
  int         n_compared        = 0;
  always #20 clock_in = ~clock_in;
  always #24 osc_clk_in = ~osc_clk_in & osc_run;
  rtc_irq_core i_dut (
    .clock_in, .rst_in, .osc_clk_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cal_weekday_in,
    .cal_hour_in, .cal_minute_in, .cal_min_roll_in, .cal_hour_roll_in,
    .cal_month_roll_in, .sec_tick_out, .irq_pin_a_o_out,
    .irq_pin_a_oe_out, .irq_pin_b_o_out, .irq_pin_b_oe_out
  );
  rtc_host_model i_host (
    .clock_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .pin_a_o_in(irq_pin_a_o_out),
    .pin_a_oe_in(irq_pin_a_oe_out), .pin_b_o_in(irq_pin_b_o_out),
    .pin_b_oe_in(irq_pin_b_oe_out), .pin_a_out(pin_a), .pin_b_out(pin_b)
  );
  // ========
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd_reg(a, d);
    check(d, exp);
  endtask : rchk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.wr_reg(a, d);
  endtask : wr
  // Pin levels {a, b} once the request path has settled
  task automatic pins(input logic [1:0] exp);
    repeat (4) @(posedge clock_in);
    #5;
    check({6'h00, pin_a, pin_b}, {6'h00, exp});
  endtask : pins
  task automatic clk_on_b;
    repeat (8) begin
      @(posedge clock_in);
      #5;
      check({6'h00, pin_a, pin_b}, {6'h00, 1'b1, osc_clk_in});
    end
  endtask : clk_on_b
  // Calendar minute leaves and re-enters the alarm time
  task automatic hit;
    @(posedge clock_in);
    cal_minute_in <= 8'h00;
    @(posedge clock_in);
    cal_minute_in <= 8'h30;
  endtask : hit
  // ========
  // Scenarios
  task automatic t_power_on;
    rchk(OFS_CTRL2, CTRL2_RST);
    wr(OFS_CTRL1, 8'hFF);
    wr(OFS_TRIM, 8'h7F);
    rchk(OFS_CTRL1, 8'h00);
    rchk(OFS_TRIM, 8'h00);
    wr(OFS_CTRL2, 8'h38);
    rchk(OFS_CTRL2, CTRL2_RST);
    rchk(4'h3, 8'h00);
    clk_on_b;
    $display("t_power_on done");
  endtask : t_power_on
  task automatic t_halt_trim;
    wr(OFS_CTRL2, 8'h00);
    rchk(OFS_CTRL2, 8'h00);
    wr(OFS_CTRL2, 8'h10);
    rchk(OFS_CTRL2, 8'h00);
    wr(OFS_TRIM, {1'b0, i_host.trim_of(-41)});
    rchk(OFS_TRIM, 8'h57);
    wr(OFS_TRIM, 8'h09);
    rchk(OFS_TRIM, 8'h09);
    wr(OFS_CTRL2, 8'h20);
    rchk(OFS_CTRL2, 8'h20);
    wr(OFS_TRIM, 8'h3F);
    clk_on_b;
    $display("t_halt_trim done");
  endtask : t_halt_trim
  task automatic t_alarm;
    wr(OFS_CTRL2, 8'h08);
    for (int u = 0; u < 2; u++) begin
      wr(OFS_ALA_MIN + 4'(3 * u), 8'h30);
      wr(OFS_ALA_HR + 4'(3 * u), 8'h12);
      wr(OFS_ALA_WDAY + 4'(3 * u), 8'h7F);
    end
    cal_hour_in <= 8'h12;
    cal_weekday_in <= 3'h5;
    wr(OFS_CTRL1, 8'hC0);
    hit;
    pins(2'b01);
    rchk(OFS_CTRL2, 8'h0B);
    wr(OFS_CTRL2, 8'h09);
    pins(2'b01);
    wr(OFS_CTRL2, 8'h08);
    pins(2'b11);
    wr(OFS_CTRL1, 8'hD0);
    hit;
    pins(2'b00);
    wr(OFS_CTRL2, 8'h09);
    pins(2'b10);
    wr(OFS_CTRL1, 8'h10);
    pins(2'b11);
    $display("t_alarm done");
  endtask : t_alarm
  task automatic t_periodic;
    int n;
    wr(OFS_CTRL1, 8'h01);
    pins(2'b01);
    wr(OFS_CTRL1, 8'h21);
    pins(2'b10);
    wr(OFS_CTRL1, 8'h20);
    pins(2'b11);
    for (int c = 4; c < 8; c++) begin
      wr(OFS_CTRL1, 8'h20 | 8'(c));
      if (c == 4) begin
        for (n = 0; n < 45000 && sec_tick_out !== 1'b1; n++) begin
          @(posedge clock_in);
          #5;
        end
        check({7'h00, sec_tick_out}, 8'h01);
      end else begin
        {cal_month_roll_in, cal_hour_roll_in, cal_min_roll_in} <=
          3'h1 << (c - 5);
        @(posedge clock_in);
        {cal_month_roll_in, cal_hour_roll_in, cal_min_roll_in} <= 3'h0;
      end
      pins(2'b10);
      rchk(OFS_CTRL2, 8'h0C);
      wr(OFS_CTRL2, 8'h08);
      pins(2'b11);
    end
    wr(OFS_CTRL1, 8'h23);
    pins(2'b10);
    osc_run = 1'b0;
    repeat (2600) @(posedge clock_in);
    osc_run = 1'b1;
    rchk(OFS_CTRL2, CTRL2_RST);
    $display("t_periodic done");
  endtask : t_periodic
  // ========
  // Verdict
  task automatic results;
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    t_power_on;
    t_halt_trim;
    t_alarm;
    t_periodic;
    results;
  end
  initial begin
    #4000000;
    fail_count++;
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    results;
  end
endmodule : rtc_trim_halt_irq_routing_bench
